// ### design/epm_pkg.sv
package epm_pkg;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [15:0] EPM_IDX_CLEAR = 16'hf421;
  localparam logic [15:0] EPM_IDX_PARITY_MASK = 16'hf422;
  localparam logic [15:0] EPM_IDX_SOFTWARE_MASK = 16'hf423;
  localparam logic [15:0] EPM_IDX_WATCHDOG_MASK = 16'hf424;
  localparam logic [15:0] EPM_IDX_STACK_MASK = 16'hf425;
  localparam logic [15:0] EPM_IDX_LOOP_MASK = 16'hf426;
  localparam logic [15:0] EPM_IDX_MASTER_FLAG = 16'hf427;
  localparam logic [15:0] EPM_IDX_FIRST_SOURCE = 16'hf428;
  localparam logic [15:0] EPM_IDX_IRQ_STATUS = 16'hf430;
  localparam logic [15:0] EPM_IDX_IRQ_MASK = 16'hf431;

  localparam logic [15:0] EPM_RST_CLEAR = 16'h0000;
  localparam logic [15:0] EPM_RST_PARITY_MASK = 16'h0003;
  localparam logic [15:0] EPM_RST_SRC_MASK = 16'h0000;
  localparam logic [15:0] EPM_RST_FIRST_SOURCE = 16'h0000;
  localparam logic [1:0] EPM_RST_IRQ = 2'h0;

  // first-error code bit positions
  localparam int EPM_BIT_SOFT = 15;
  localparam int EPM_BIT_LOOP = 14;
  localparam int EPM_BIT_STACK = 13;
  localparam int EPM_BIT_WDOG = 12;
  localparam int EPM_PARITY_W = 12;

  // interrupt status bits
  localparam int EPM_IRQ_FIRST = 0;
  localparam int EPM_IRQ_LATER = 1;

  localparam logic [1:0] EPM_RESP_OKAY = 2'h0;
  localparam logic [1:0] EPM_RESP_SLVERR = 2'h2;
endpackage : epm_pkg

// ### design/epm_error_panic_manager.sv
// Behaviour
// - software panic reported unless its mask bit set
// - watchdog expiry reported unless its mask bit set
// - stack overrun reported unless its mask bit set
// - loop overrun reported unless its mask bit set
// - any unmasked error sets master flag
// - master flag sticky until clear event
// - clear bit rising edge resets flag, code unless an unmasked error is present in that cycle
// - code register holds only the error sources present in the first error cycle
// - capture resumes only after clear resets code
// - code bit 15 marks software panic
// - code bit 14 marks loop overrun
// - code bit 13 marks stack overrun
// - code bit 12 marks watchdog expiry
// - code bit 11 marks data memory 1 bank 3
// - code bits 10..0 map remaining parity sources
// - parity mask gates each memory; rate converters masked
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module epm_error_panic_manager
  import epm_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_err_soft,
  input wire logic i_err_loop,
  input wire logic i_err_stack,
  input wire logic i_err_wdog,
  input wire logic [EPM_PARITY_W-1:0] i_err_parity,
  output logic o_master_flag,
  output logic o_irq,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);

  logic [15:0] clear_q;
  logic clear_prev_q;
  logic [15:0] parity_mask_q;
  logic [15:0] sw_mask_q;
  logic [15:0] wd_mask_q;
  logic [15:0] stack_mask_q;
  logic [15:0] loop_mask_q;
  logic flag_q;
  logic [15:0] code_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;

  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  logic wr_fire;
  logic [15:0] wr_idx;
  logic wr_ok;
  logic [15:0] rd_idx;
  logic rd_ok;
  logic [15:0] rd_val;
  logic clear_edge;
  logic [15:0] err_vec;
  logic any_err;
  logic [1:0] irq_ev;
  logic [1:0] irq_clr;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction : merge16

  function automatic logic map_ok(input logic [ADDR_W-1:0] a);
    logic [15:0] ix;
    logic hi_ok;
    ix = a[17:2];
    hi_ok = (a >> 18) == '0;
    return hi_ok && (((ix >= EPM_IDX_CLEAR) && (ix <= EPM_IDX_FIRST_SOURCE)) ||
                     (ix == EPM_IDX_IRQ_STATUS) || (ix == EPM_IDX_IRQ_MASK));
  endfunction : map_ok

  // error gating; bit 0 of each source mask is the only live bit
  always_comb begin
    err_vec = '0;
    err_vec[EPM_BIT_SOFT] = i_err_soft & ~sw_mask_q[0];
    err_vec[EPM_BIT_WDOG] = i_err_wdog & ~wd_mask_q[0];
    err_vec[EPM_BIT_STACK] = i_err_stack & ~stack_mask_q[0];
    err_vec[EPM_BIT_LOOP] = i_err_loop & ~loop_mask_q[0];
    err_vec[EPM_PARITY_W-1:0] = i_err_parity;
    err_vec[EPM_PARITY_W-1:0] &= ~parity_mask_q[EPM_PARITY_W-1:0];
  end

  assign any_err = |err_vec;
  assign clear_edge = clear_q[0] & ~clear_prev_q;

  // register bus: write path
  assign o_awready = ~aw_held_q & ~bvalid_q;
  assign o_wready = ~w_held_q & ~bvalid_q;
  assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_idx = awaddr_q[17:2];
  assign wr_ok = map_ok(awaddr_q);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (i_awvalid && o_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= i_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (i_wvalid && o_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= i_wdata;
      wstrb_q <= i_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bvalid_q <= 1'b0;
      bresp_q <= EPM_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? EPM_RESP_OKAY : EPM_RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;

  // software-written registers; reserved bits outside the interrupt mask are kept but drive nothing
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clear_q <= EPM_RST_CLEAR;
      parity_mask_q <= EPM_RST_PARITY_MASK;
      sw_mask_q <= EPM_RST_SRC_MASK;
      wd_mask_q <= EPM_RST_SRC_MASK;
      stack_mask_q <= EPM_RST_SRC_MASK;
      loop_mask_q <= EPM_RST_SRC_MASK;
      irq_mask_q <= EPM_RST_IRQ;
    end else if (wr_fire && wr_ok) begin
      // flag and code indices fall through: read-only
      case (wr_idx)
        EPM_IDX_CLEAR: clear_q <= merge16(clear_q, wdata_q, wstrb_q);
        EPM_IDX_PARITY_MASK: parity_mask_q <= merge16(parity_mask_q, wdata_q, wstrb_q);
        EPM_IDX_SOFTWARE_MASK: sw_mask_q <= merge16(sw_mask_q, wdata_q, wstrb_q);
        EPM_IDX_WATCHDOG_MASK: wd_mask_q <= merge16(wd_mask_q, wdata_q, wstrb_q);
        EPM_IDX_STACK_MASK: stack_mask_q <= merge16(stack_mask_q, wdata_q, wstrb_q);
        EPM_IDX_LOOP_MASK: loop_mask_q <= merge16(loop_mask_q, wdata_q, wstrb_q);
        EPM_IDX_IRQ_MASK: begin
          if (wstrb_q[0]) begin
            irq_mask_q <= wdata_q[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clear_prev_q <= 1'b0;
    end else begin
      clear_prev_q <= clear_q[0];
    end
  end

  // panic core: a fresh error in the clear cycle wins and is captured
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flag_q <= 1'b0;
      code_q <= EPM_RST_FIRST_SOURCE;
    end else if (clear_edge) begin
      flag_q <= any_err;
      code_q <= err_vec;
    end else if (!flag_q && any_err) begin
      flag_q <= 1'b1;
      code_q <= err_vec;
    end
  end

  assign o_master_flag = flag_q;

  // interrupt status: bit 0 on first error, bit 1 on later error while flag held; write one to clear
  always_comb begin
    irq_ev = '0;
    irq_clr = '0;
    irq_ev[EPM_IRQ_FIRST] = any_err & (~flag_q | clear_edge);
    irq_ev[EPM_IRQ_LATER] = any_err & flag_q & ~clear_edge;
    if (wr_fire && wr_ok && wr_idx == EPM_IDX_IRQ_STATUS && wstrb_q[0]) begin
      irq_clr = wdata_q[1:0];
    end
  end

  // an event in the clearing cycle wins, so no error is lost to a racing clear
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_status_q <= EPM_RST_IRQ;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_ev;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status_q & ~irq_mask_q);
    end
  end

  // register bus: read path
  assign o_arready = ~rvalid_q;
  assign rd_idx = i_araddr[17:2];
  assign rd_ok = map_ok(i_araddr);

  always_comb begin
    case (rd_idx)
      EPM_IDX_CLEAR: rd_val = clear_q;
      EPM_IDX_PARITY_MASK: rd_val = parity_mask_q;
      EPM_IDX_SOFTWARE_MASK: rd_val = sw_mask_q;
      EPM_IDX_WATCHDOG_MASK: rd_val = wd_mask_q;
      EPM_IDX_STACK_MASK: rd_val = stack_mask_q;
      EPM_IDX_LOOP_MASK: rd_val = loop_mask_q;
      EPM_IDX_MASTER_FLAG: rd_val = {15'h0000, flag_q};
      EPM_IDX_FIRST_SOURCE: rd_val = code_q;
      EPM_IDX_IRQ_STATUS: rd_val = {14'h0000, irq_status_q};
      EPM_IDX_IRQ_MASK: rd_val = {14'h0000, irq_mask_q};
      default: rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= EPM_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_ok ? {16'h0000, rd_val} : 32'h00000000;
      rresp_q <= rd_ok ? EPM_RESP_OKAY : EPM_RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  property p_soft_masked;
    $rose(code_q[EPM_BIT_SOFT]) |-> $past(i_err_soft) && !$past(sw_mask_q[0]);
  endproperty
  a_soft_masked: assert property (p_soft_masked) else $error("soft code while masked");

  property p_wdog_masked;
    $rose(code_q[EPM_BIT_WDOG]) |-> $past(i_err_wdog) && !$past(wd_mask_q[0]);
  endproperty
  a_wdog_masked: assert property (p_wdog_masked) else $error("wdog code while masked");

  property p_stack_masked;
    $rose(code_q[EPM_BIT_STACK]) |-> $past(i_err_stack) && !$past(stack_mask_q[0]);
  endproperty
  a_stack_masked: assert property (p_stack_masked) else $error("masked stack captured");

  property p_loop_masked;
    $rose(code_q[EPM_BIT_LOOP]) |-> $past(i_err_loop) && !$past(loop_mask_q[0]);
  endproperty
  a_loop_masked: assert property (p_loop_masked) else $error("loop code while masked");

  property p_flag_sets;
    (!flag_q && any_err) |=> flag_q;
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("flag missed unmasked error");

  sequence s_held_no_clear;
    flag_q && !clear_edge;
  endsequence

  property p_flag_sticky;
    s_held_no_clear |=> flag_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag fell without clear");

  property p_clear_resets;
    (clear_edge && !any_err) |=> !flag_q && code_q == 16'h0000;
  endproperty
  a_clear_resets: assert property (p_clear_resets) else $error("clear left state set");

  property p_code_frozen;
    s_held_no_clear |=> $stable(code_q);
  endproperty
  a_code_frozen: assert property (p_code_frozen) else $error("code changed while held");

  property p_capture_all;
    (!flag_q && any_err) |=> code_q == $past(err_vec);
  endproperty
  a_capture_all: assert property (p_capture_all) else $error("first code incomplete");

  property p_parity_masked;
    $rose(code_q[0]) |-> $past(i_err_parity[0]) && !$past(parity_mask_q[0]);
  endproperty
  a_parity_masked: assert property (p_parity_masked) else $error("masked parity seen");

  property p_flag_code_agree;
    flag_q == (code_q != 16'h0000);
  endproperty
  a_flag_code_agree: assert property (p_flag_code_agree) else $error("flag vs code");

  property p_top_bank;
    $rose(code_q[EPM_PARITY_W-1]) |->
      $past(i_err_parity[EPM_PARITY_W-1]) && !$past(parity_mask_q[EPM_PARITY_W-1]);
  endproperty
  a_top_bank: assert property (p_top_bank) else $error("bank code while masked");

  sequence s_write_pair;
    aw_held_q && w_held_q && !bvalid_q;
  endsequence

  property p_b_follows;
    s_write_pair |=> o_bvalid;
  endproperty
  a_b_follows: assert property (p_b_follows) else $error("write response missing");

  property p_r_follows;
    (i_arvalid && o_arready) |=> o_rvalid;
  endproperty
  a_r_follows: assert property (p_r_follows) else $error("read data missing");

  property p_irq_first;
    (any_err && !flag_q) |=> irq_status_q[EPM_IRQ_FIRST];
  endproperty
  a_irq_first: assert property (p_irq_first) else $error("first irq status missing");

endmodule : epm_error_panic_manager
`default_nettype wire

// ### tb/epm_error_panic_manager_tb.sv
`timescale 1ns/100ps
`default_nettype none
module epm_error_panic_manager_tb;
  import epm_pkg::*;
  logic i_mclk, i_rst_b, i_err_soft, i_err_loop, i_err_stack, i_err_wdog;
  logic [11:0] i_err_parity;
  logic [31:0] i_awaddr, i_araddr, i_wdata;
  logic [3:0] i_wstrb;
  logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_master_flag, o_irq, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  int fail_count = 0;
  int num_checks = 0;
  logic [15:0] lfsr_q = 16'h0046;
  localparam logic [15:0] MASK_IDX [4] = '{EPM_IDX_SOFTWARE_MASK, EPM_IDX_LOOP_MASK,
    EPM_IDX_STACK_MASK, EPM_IDX_WATCHDOG_MASK};
  localparam logic [15:0] RST_TBL [7] = '{16'h0003, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000};

  epm_error_panic_manager #(.ADDR_W(32)) DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_err_soft(i_err_soft), .i_err_loop(i_err_loop), .i_err_stack(i_err_stack),
    .i_err_wdog(i_err_wdog), .i_err_parity(i_err_parity), .o_master_flag(o_master_flag),
    .o_irq(o_irq), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_rvalid(o_rvalid), .i_rready(i_rready));

  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // source order soft, loop, stack, watchdog matches code bits 15..12
  function automatic logic [15:0] exp_code(input logic [3:0] src, input logic [11:0] par,
                                           input logic [11:0] pm);
    return {src, par & ~pm};
  endfunction : exp_code

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic timeout();
    fail_count++;
    $display("BAD bus handshake expected answer seen none");
    stop_test();
  endtask : timeout

  task automatic chk_val(input string what, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk_val

  task automatic chk_bit(input string what, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit

  task automatic chk_resp(input string what, input logic [1:0] e, input logic [1:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk_resp

  // handshakes judged mid-cycle: at the edge itself the readies race the design
  task automatic axi_write(input logic [15:0] idx, input logic [15:0] d,
                           output logic [1:0] resp);
    int n;
    logic aw_go;
    logic w_go;
    logic b_go;
    resp = 2'h3;
    @(posedge i_mclk);
    i_awaddr <= {14'h0, idx, 2'h0};
    i_wdata <= {16'h0, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge i_mclk);
      aw_go = i_awvalid & o_awready;
      w_go = i_wvalid & o_wready;
      b_go = o_bvalid === 1'b1;
      resp = o_bresp;
      @(posedge i_mclk);
      if (aw_go) i_awvalid <= 1'b0;
      if (w_go) i_wvalid <= 1'b0;
      if (b_go) break;
    end
    i_bready <= 1'b0;
    if (n == 64) timeout();
  endtask : axi_write

  task automatic axi_read(input logic [15:0] idx, output logic [15:0] d,
                          output logic [1:0] resp);
    int n;
    logic ar_go;
    logic r_go;
    d = 16'h0000;
    resp = 2'h3;
    @(posedge i_mclk);
    i_araddr <= {14'h0, idx, 2'h0};
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge i_mclk);
      ar_go = i_arvalid & o_arready;
      r_go = o_rvalid === 1'b1;
      d = o_rdata[15:0];
      resp = o_rresp;
      @(posedge i_mclk);
      if (ar_go) i_arvalid <= 1'b0;
      if (r_go) break;
    end
    i_rready <= 1'b0;
    if (n == 64) timeout();
  endtask : axi_read

  task automatic pulse(input logic [3:0] src, input logic [11:0] par);
    @(posedge i_mclk);
    {i_err_soft, i_err_loop, i_err_stack, i_err_wdog} <= src;
    i_err_parity <= par;
    @(posedge i_mclk);
    {i_err_soft, i_err_loop, i_err_stack, i_err_wdog} <= 4'h0;
    i_err_parity <= 12'h000;
    repeat (2) @(posedge i_mclk);
  endtask : pulse

  // clear acts on the rising edge only, hence the full 0,1,0 sequence
  task automatic clear_panic();
    logic [1:0] rs;
    axi_write(EPM_IDX_CLEAR, 16'h0000, rs);
    axi_write(EPM_IDX_CLEAR, 16'h0001, rs);
    axi_write(EPM_IDX_CLEAR, 16'h0000, rs);
  endtask : clear_panic

  initial begin
    logic [15:0] rd;
    logic [1:0] rs;
    logic [3:0] src;
    logic [11:0] par, pm;
    {i_rst_b, i_err_soft, i_err_loop, i_err_stack, i_err_wdog} = 5'h0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h0;
    i_err_parity = 12'h000;
    i_awaddr = 32'h0;
    i_araddr = 32'h0;
    i_wdata = 32'h0;
    i_wstrb = 4'h3;
    repeat (16) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      axi_read(EPM_IDX_PARITY_MASK + 16'(k), rd, rs);
      chk_val("reset value", RST_TBL[k], rd);
    end
    for (int k = 0; k < 4; k++) begin
      axi_write(MASK_IDX[k], 16'h0001, rs);
      pulse(4'h8 >> k, 12'h000);
      chk_bit("flag masked", 1'b0, o_master_flag);
      axi_write(MASK_IDX[k], 16'h0000, rs);
      pulse(4'h8 >> k, 12'h000);
      chk_bit("flag set", 1'b1, o_master_flag);
      axi_read(EPM_IDX_FIRST_SOURCE, rd, rs);
      chk_val("code", 16'h8000 >> k, rd);
      pulse(4'h8 >> ((k + 1) % 4), 12'hfff);
      axi_read(EPM_IDX_FIRST_SOURCE, rd, rs);
      chk_val("code held", 16'h8000 >> k, rd);
      chk_bit("flag held", 1'b1, o_master_flag);
      clear_panic();
      axi_read(EPM_IDX_FIRST_SOURCE, rd, rs);
      chk_val("code cleared", 16'h0000, rd);
      axi_read(EPM_IDX_MASTER_FLAG, rd, rs);
      chk_val("flag cleared", 16'h0000, rd);
    end
    axi_write(EPM_IDX_SOFTWARE_MASK, 16'hfffe, rs);
    axi_read(EPM_IDX_SOFTWARE_MASK, rd, rs);
    chk_val("reserved bits", 16'hfffe, rd);
    pulse(4'h8, 12'h000);
    chk_bit("flag reserved", 1'b1, o_master_flag);
    clear_panic();
    axi_write(EPM_IDX_SOFTWARE_MASK, 16'h0000, rs);
    for (int i = 0; i < 24; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      src = (i < 2) ? 4'h0 : lfsr_q[15:12];
      par = (i == 0) ? 12'h800 : (i == 1) ? 12'hfff : lfsr_q[11:0];
      lfsr_q = lfsr_next(lfsr_q);
      pm = (i < 2) ? 12'h000 : lfsr_q[11:0];
      axi_write(EPM_IDX_PARITY_MASK, {4'h0, pm}, rs);
      pulse(src, par);
      axi_read(EPM_IDX_FIRST_SOURCE, rd, rs);
      chk_val("parity code", exp_code(src, par, pm), rd);
      chk_bit("parity flag", |exp_code(src, par, pm), o_master_flag);
      clear_panic();
    end
    pulse(4'h1, 12'h000);
    axi_write(EPM_IDX_FIRST_SOURCE, 16'hffff, rs);
    chk_resp("ro write resp", EPM_RESP_OKAY, rs);
    axi_write(EPM_IDX_MASTER_FLAG, 16'h0000, rs);
    axi_read(EPM_IDX_FIRST_SOURCE, rd, rs);
    chk_val("ro code", 16'h1000, rd);
    chk_bit("ro flag", 1'b1, o_master_flag);
    axi_write(16'hf429, 16'h1234, rs);
    chk_resp("unmapped write", EPM_RESP_SLVERR, rs);
    axi_read(16'hf429, rd, rs);
    chk_resp("unmapped read", EPM_RESP_SLVERR, rs);
    chk_val("unmapped data", 16'h0000, rd);
    chk_bit("irq raised", 1'b1, o_irq);
    axi_read(EPM_IDX_IRQ_STATUS, rd, rs);
    chk_val("irq first and later", 16'h0003, rd);
    axi_write(EPM_IDX_IRQ_MASK, 16'h0003, rs);
    repeat (2) @(posedge i_mclk);
    chk_bit("irq masked", 1'b0, o_irq);
    axi_write(EPM_IDX_IRQ_STATUS, 16'h0003, rs);
    axi_write(EPM_IDX_IRQ_MASK, 16'h0000, rs);
    repeat (2) @(posedge i_mclk);
    chk_bit("irq cleared", 1'b0, o_irq);
    clear_panic();
    pulse(4'h4, 12'h000);
    chk_bit("irq again", 1'b1, o_irq);
    axi_read(EPM_IDX_IRQ_STATUS, rd, rs);
    chk_val("irq status", 16'h0001, rd);
    stop_test();
  end
endmodule : epm_error_panic_manager_tb
`default_nettype wire
